// ===== shared/pwmb_pkg.sv
package pwmb_pkg;
    // Register indexes; the byte address on the bus is four times the index
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_CNT_LO = 16'hf8b4;
    localparam logic [15:0] IDX_CNT_HI = 16'hf8b5;
    localparam logic [15:0] IDX_CTL0 = 16'hf8b6;
    localparam logic [15:0] IDX_CTL1 = 16'hf8b7;
    localparam logic [15:0] IDX_CTL2 = 16'hf8b8;

    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h40;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [7:0] CTL2_MASK = 8'h5f;

    // Control zero fields
    localparam int C0_CS = 0;
    localparam int C0_IS = 2;
    localparam int C0_NEG = 4;
    localparam int C0_INI = 5;
    localparam int C0_STP = 6;
    localparam int C0_CLIG = 7;
    // Control one fields
    localparam int C1_RUN = 0;
    localparam int C1_FLG = 6;
    localparam int C1_STAT = 7;
    // Control two fields
    localparam int C2_TGE = 0;
    localparam int C2_STM = 2;
    localparam int C2_TGSEL = 4;
    localparam int C2_MD = 6;

    localparam logic [1:0] CS_LOW = 2'h0;
    localparam logic [1:0] CS_HTB = 2'h1;
    localparam logic [1:0] CS_EXT = 2'h2;
    localparam logic [1:0] CS_OFF = 2'h3;

    localparam logic [1:0] IS_PERIOD = 2'h0;
    localparam logic [1:0] IS_DUTY = 2'h1;

    localparam logic [1:0] STM_SW = 2'h0;
    localparam logic [1:0] STM_SW_EXT = 2'h1;
    localparam logic [1:0] STM_EXT = 2'h2;
    localparam logic [1:0] STM_SW_CLR = 2'h3;

    localparam logic [1:0] TGE_NONE = 2'h0;
    localparam logic [1:0] TGE_RISE = 2'h1;
    localparam logic [1:0] TGE_FALL = 2'h2;
    localparam logic [1:0] TGE_BOTH = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int LS_DIV_DEF = 610;
    localparam int HTB_DIV_DEF = 2;
endpackage : pwmb_pkg

// ===== verilog/pwmb_ctrl.sv
// Register access over AXI4-Lite is this design's own decision.
module pwmb_ctrl #(
    parameter int LS_DIV = pwmb_pkg::LS_DIV_DEF,
    parameter int HTB_DIV = pwmb_pkg::HTB_DIV_DEF
) (
    input wire logic clk, // 20 MHz oscillator clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [pwmb_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [pwmb_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [15:0] period_value, // Period from the period register
    input wire logic [15:0] duty_value, // Duty from the duty register
    input wire logic cooperation_mode, // Channel pair cooperation
    input wire logic partner_count_run, // Partner run bit
    input wire logic partner_clear_inhibit, // Partner clear-inhibit bit
    input wire logic partner_trigger_pin_select, // Partner trigger-pin bit
    input wire logic partner_one_shot_select, // Partner one-shot bit
    input wire logic [1:0] partner_start_mode, // Partner start-mode field
    input wire logic [1:0] partner_trigger_edge, // Partner trigger-edge field
    input wire logic shared_event_pin_a, // Trigger pin a
    input wire logic shared_event_pin_b, // Trigger pin b
    input wire logic external_count_clock_pin, // External count clock pin
    output logic pwm_out, // Channel output
    output logic irq // Channel interrupt pulse
);
    localparam logic [pwmb_pkg::ADDR_W-1:0] A_CNT_LO = {pwmb_pkg::IDX_CNT_LO, 2'b00};
    localparam logic [pwmb_pkg::ADDR_W-1:0] A_CNT_HI = {pwmb_pkg::IDX_CNT_HI, 2'b00};
    localparam logic [pwmb_pkg::ADDR_W-1:0] A_CTL0 = {pwmb_pkg::IDX_CTL0, 2'b00};
    localparam logic [pwmb_pkg::ADDR_W-1:0] A_CTL1 = {pwmb_pkg::IDX_CTL1, 2'b00};
    localparam logic [pwmb_pkg::ADDR_W-1:0] A_CTL2 = {pwmb_pkg::IDX_CTL2, 2'b00};

    // Bus slave state
    logic aw_have_q, w_have_q;
    logic [pwmb_pkg::ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic wr_go;

    // Registers and channel state
    logic [7:0] ctl0_q, ctl2_q;
    logic run_q, counting_q, counting_d, flag_q;
    logic [15:0] cnt_q;
    logic pwm_out_q, irq_q;

    // Clock enables
    logic [15:0] ls_div_q, htb_div_q;
    logic ls_tick, htb_tick, ext_tick, tick, sample_en;
    logic [1:0] ext_sync_q;
    logic ext_prev_q;
    logic [1:0] pa_sync_q, pb_sync_q;
    logic trig_smp_q, trig_prev_q;
    logic trig_rise, trig_fall;
    logic partner_run_prev_q;

    // Decoded controls
    logic [1:0] cs, stm, tge;
    logic clig, tgsel, one_shot, init_level;
    logic wr_ctl0, wr_ctl1, wr_ctl2, wr_cnt;
    logic sw_allowed, sw_start, sw_stop;
    logic ext_start, ext_stop, ext_clear;
    logic per_match, duty_match, oneshot_end, pause_evt;

    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_ctl0 = wr_go & wlane_q & (awaddr_q == A_CTL0);
    assign wr_ctl1 = wr_go & wlane_q & (awaddr_q == A_CTL1);
    assign wr_ctl2 = wr_go & wlane_q & (awaddr_q == A_CTL2);
    assign wr_cnt = wr_go & wlane_q & ((awaddr_q == A_CNT_LO) | (awaddr_q == A_CNT_HI));

    // Write address and data are taken independently, answered once both are held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pwmb_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if ((awaddr_q == A_CTL0) || (awaddr_q == A_CTL1) || (awaddr_q == A_CTL2) ||
                    (awaddr_q == A_CNT_LO) || (awaddr_q == A_CNT_HI)) begin
                    s_axi_bresp <= pwmb_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= pwmb_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pwmb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pwmb_pkg::RESP_OKAY;
            case (s_axi_araddr)
                A_CTL0: s_axi_rdata <= {24'h000000, ctl0_q};
                A_CTL1: s_axi_rdata <= {24'h000000, counting_q, flag_q, 5'h00, run_q};
                A_CTL2: s_axi_rdata <= {24'h000000, ctl2_q};
                A_CNT_LO: s_axi_rdata <= {24'h000000, cnt_q[7:0]};
                A_CNT_HI: s_axi_rdata <= {24'h000000, cnt_q[15:8]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= pwmb_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl0_q <= pwmb_pkg::CTL0_RST;
            ctl2_q <= pwmb_pkg::CTL2_RST;
        end else begin
            if (wr_ctl0) begin
                ctl0_q <= wdata_q;
            end
            if (wr_ctl2) begin
                ctl2_q <= wdata_q & pwmb_pkg::CTL2_MASK;
            end
        end
    end

    assign cs = ctl0_q[pwmb_pkg::C0_CS +: 2];
    assign init_level = ~(ctl0_q[pwmb_pkg::C0_INI] ^ ctl0_q[pwmb_pkg::C0_NEG]);
    assign clig = cooperation_mode ? partner_clear_inhibit : ctl0_q[pwmb_pkg::C0_CLIG];
    assign tgsel = cooperation_mode ? partner_trigger_pin_select : ctl2_q[pwmb_pkg::C2_TGSEL];
    assign one_shot = cooperation_mode ? partner_one_shot_select : ctl2_q[pwmb_pkg::C2_MD];
    assign stm = cooperation_mode ? partner_start_mode : ctl2_q[pwmb_pkg::C2_STM +: 2];
    assign tge = cooperation_mode ? partner_trigger_edge : ctl2_q[pwmb_pkg::C2_TGE +: 2];

    // Dividers for the slower count and sampling rates
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ls_div_q <= 16'h0000;
            htb_div_q <= 16'h0000;
        end else begin
            ls_div_q <= ls_tick ? 16'h0000 : ls_div_q + 16'h0001;
            htb_div_q <= htb_tick ? 16'h0000 : htb_div_q + 16'h0001;
        end
    end
    assign ls_tick = (ls_div_q == 16'(LS_DIV - 1));
    assign htb_tick = (htb_div_q == 16'(HTB_DIV - 1));

    // Pin synchronisers
    // Only the second stage of each synchroniser feeds logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_sync_q <= 2'b00;
            ext_prev_q <= 1'b0;
            pa_sync_q <= 2'b00;
            pb_sync_q <= 2'b00;
        end else begin
            ext_sync_q <= {ext_sync_q[0], external_count_clock_pin};
            ext_prev_q <= ext_sync_q[1];
            pa_sync_q <= {pa_sync_q[0], shared_event_pin_a};
            pb_sync_q <= {pb_sync_q[0], shared_event_pin_b};
        end
    end
    assign ext_tick = ext_sync_q[1] & ~ext_prev_q;

    always_comb begin
        case (cs)
            pwmb_pkg::CS_LOW: tick = ls_tick;
            pwmb_pkg::CS_HTB: tick = htb_tick;
            pwmb_pkg::CS_EXT: tick = ext_tick;
            default: tick = 1'b0;
        endcase
    end
    assign sample_en = (cs == pwmb_pkg::CS_HTB) ? 1'b1 : ls_tick;

    // Trigger pin sampling and edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_smp_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else if (sample_en) begin
            trig_smp_q <= tgsel ? pb_sync_q[1] : pa_sync_q[1];
            trig_prev_q <= trig_smp_q;
        end
    end
    // Edge seen between two successive samples
    assign trig_rise = sample_en & trig_smp_q & ~trig_prev_q;
    assign trig_fall = sample_en & ~trig_smp_q & trig_prev_q;

    // Start, stop and clear sources
    assign sw_allowed = (stm != pwmb_pkg::STM_EXT);
    assign sw_start = wr_ctl1 & wdata_q[pwmb_pkg::C1_RUN] & sw_allowed;
    assign sw_stop = wr_ctl1 & ~wdata_q[pwmb_pkg::C1_RUN] & sw_allowed;

    // Clear mode honours the inhibit against the current flag
    always_comb begin
        ext_start = 1'b0;
        ext_stop = 1'b0;
        ext_clear = 1'b0;
        if ((stm == pwmb_pkg::STM_SW_EXT) || (stm == pwmb_pkg::STM_EXT)) begin
            case (tge)
                pwmb_pkg::TGE_RISE: begin
                    ext_start = trig_rise;
                    ext_stop = trig_fall;
                end
                pwmb_pkg::TGE_FALL: begin
                    ext_start = trig_fall;
                    ext_stop = trig_rise;
                end
                default: begin
                    ext_start = 1'b0;
                end
            endcase
        end else if (stm == pwmb_pkg::STM_SW_CLR) begin
            case (tge)
                pwmb_pkg::TGE_RISE: ext_clear = trig_fall;
                pwmb_pkg::TGE_FALL: ext_clear = trig_rise;
                pwmb_pkg::TGE_BOTH: ext_clear = trig_rise | trig_fall;
                default: ext_clear = 1'b0;
            endcase
            if (clig && flag_q) begin
                ext_clear = 1'b0;
            end
        end
    end

    // Matches only on a tick while counting
    assign per_match = tick & counting_q & (cnt_q == period_value);
    assign duty_match = tick & counting_q & (cnt_q == duty_value);
    assign oneshot_end = per_match & one_shot;

    // Stops first, so a start in the same cycle wins
    always_comb begin
        counting_d = counting_q;
        if (oneshot_end || ext_stop || sw_stop) begin
            counting_d = 1'b0;
        end
        if (sw_start || ext_start) begin
            counting_d = 1'b1;
        end
        if (cs == pwmb_pkg::CS_OFF) begin
            counting_d = 1'b0;
        end
    end

    // Pause point for the stop-level choice
    assign pause_evt = cooperation_mode ? (partner_run_prev_q & ~partner_count_run)
                                        : (counting_q & ~counting_d);

    // Run bit: software write 1 wins over the one-shot clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            counting_q <= 1'b0;
            partner_run_prev_q <= 1'b0;
        end else begin
            partner_run_prev_q <= partner_count_run;
            counting_q <= counting_d;
            if (wr_ctl1) begin
                run_q <= wdata_q[pwmb_pkg::C1_RUN];
            end else if (oneshot_end) begin
                run_q <= 1'b0;
            end
        end
    end

    // Counter and output flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            flag_q <= 1'b1;
        end else if (wr_cnt) begin
            cnt_q <= 16'h0000;
            flag_q <= 1'b1;
        end else if (ext_clear || ext_stop) begin
            cnt_q <= 16'h0000;
            flag_q <= 1'b1;
        end else if (per_match) begin
            cnt_q <= 16'h0000;
            flag_q <= 1'b1;
        end else if (tick && counting_q) begin
            cnt_q <= cnt_q + 16'h0001;
            if (duty_match) begin
                flag_q <= 1'b0;
            end
        end
    end

    // Output level and interrupt pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_out_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            if (pause_evt && ctl0_q[pwmb_pkg::C0_STP]) begin
                pwm_out_q <= init_level;
            end else if (counting_q) begin
                pwm_out_q <= flag_q ? init_level : ~init_level;
            end
            case (ctl0_q[pwmb_pkg::C0_IS +: 2])
                pwmb_pkg::IS_PERIOD: irq_q <= per_match;
                pwmb_pkg::IS_DUTY: irq_q <= duty_match;
                default: irq_q <= per_match | duty_match;
            endcase
        end
    end

    assign pwm_out = pwm_out_q;
    assign irq = irq_q;
endmodule : pwmb_ctrl

// ===== dv/pwmb_ctrl_checker.sv
module pwmb_ctrl_checker (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Response valid
    input wire logic s_axi_bready, // Response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic pwm_out, // Channel output
    input wire logic irq // Interrupt pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    a_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_rdata_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_irq_pulse: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    a_reset_levels: assert property (
        disable iff (1'h0) !rst_n |=> pwm_out && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("reset levels wrong");
endmodule : pwmb_ctrl_checker

bind pwmb_ctrl pwmb_ctrl_checker u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pwm_out, .irq);

// ===== dv/pwmb_pins_model.sv
module pwmb_pins_model (
    input wire logic clk, // Clock
    input wire logic lvl_a, // Wanted level of pin a
    input wire logic lvl_b, // Wanted level of pin b
    input wire logic xclk_on, // Run the external clock
    output logic pin_a, // Shared event pin a
    output logic pin_b, // Shared event pin b
    output logic xclk // External count clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q = 2'h0;
    initial begin
        pin_a = 1'h0;
        pin_b = 1'h0;
        xclk = 1'h0;
    end
    // External clock toggles every third edge and stands low while stopped
    always @(posedge clk) begin
        pin_a <= lvl_a;
        pin_b <= lvl_b;
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        xclk <= xclk_on & (xclk ^ (div_q == 2'h2));
    end
endmodule : pwmb_pins_model

// ===== dv/testbench.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] C0 = pwmb_pkg::IDX_CTL0;
    localparam logic [15:0] C1 = pwmb_pkg::IDX_CTL1;
    localparam logic [15:0] C2 = pwmb_pkg::IDX_CTL2;
    localparam logic [15:0] CL = pwmb_pkg::IDX_CNT_LO;
    localparam logic [1:0] OK = pwmb_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pwmb_pkg::RESP_SLVERR;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [17:0] s_axi_awaddr = 18'h0;
    logic [17:0] s_axi_araddr = 18'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] period_value = 16'h0004;
    logic [15:0] duty_value = 16'h0002;
    logic cooperation_mode = 1'h0;
    logic partner_count_run = 1'h0;
    logic partner_clear_inhibit = 1'h0;
    logic partner_trigger_pin_select = 1'h0;
    logic partner_one_shot_select = 1'h0;
    logic [1:0] partner_start_mode = 2'h0;
    logic [1:0] partner_trigger_edge = 2'h0;
    logic lvl_a = 1'h0;
    logic lvl_b = 1'h0;
    logic xclk_on = 1'h0;
    logic shared_event_pin_a, shared_event_pin_b, external_count_clock_pin;
    logic [7:0] d;
    int n_fail = 0;
    int n_checks = 0;
    int n_irq = 0;

    always #25 clk = ~clk;
    always @(posedge clk) n_irq += (irq === 1'h1);

    pwmb_ctrl #(.LS_DIV(4), .HTB_DIV(2)) dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .period_value, .duty_value, .cooperation_mode, .partner_count_run, .partner_clear_inhibit,
        .partner_trigger_pin_select, .partner_one_shot_select, .partner_start_mode, .partner_trigger_edge,
        .shared_event_pin_a, .shared_event_pin_b, .external_count_clock_pin, .pwm_out, .irq);
    pwmb_pins_model u_pins (.clk, .lvl_a, .lvl_b, .xclk_on, .pin_a(shared_event_pin_a),
        .pin_b(shared_event_pin_b), .xclk(external_count_clock_pin));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [15:0] i, input logic [7:0] v, input logic [1:0] er);
        logic aw;
        logic w;
        @(posedge clk);
        aw = 1'h1;
        w = 1'h1;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, er)
    endtask : wr

    task automatic rd(input logic [15:0] i, output logic [7:0] v, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        v = s_axi_rdata[7:0];
        `CHK(s_axi_rresp, er)
    endtask : rd

    task automatic chk_stat(input logic e);
        rd(C1, d, OK);
        `CHK(d[7], e)
    endtask : chk_stat

    task automatic wait_low;
        do @(posedge clk); while (pwm_out !== 1'h0);
    endtask : wait_low

    task automatic t_reset;
        rd(C0, d, OK);
        `CHK(d, 8'h00)
        rd(C1, d, OK);
        `CHK(d, 8'h40)
        rd(C2, d, OK);
        `CHK(d, 8'h00)
        `CHK(pwm_out, 1'h1)
        rd(16'h0001, d, ER);
        `CHK(d, 8'h00)
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs;
        wr(C1, 8'hff, OK);
        rd(C1, d, OK);
        `CHK(d & 8'hbf, 8'h81)
        wr(C1, 8'h00, OK);
        cyc(4);
        rd(C1, d, OK);
        `CHK(d & 8'hbf, 8'h00)
        wr(C2, 8'hff, OK);
        rd(C2, d, OK);
        `CHK(d, 8'h5f)
        wr(C2, 8'h00, OK);
        wr(C0, 8'ha5, OK);
        rd(C0, d, OK);
        `CHK(d, 8'ha5)
        wr(C0, 8'h00, OK);
        wr(16'h0003, 8'h11, ER);
        $display("test registers done");
    endtask : t_regs

    task automatic t_irq;
        int n;
        int e;
        for (int s = 0; s < 4; s++) begin
            wr(C0, {4'h0, s[1:0], 2'h1}, OK);
            wr(C1, 8'h01, OK);
            n_irq = 0;
            cyc(400);
            n = n_irq;
            wr(C1, 8'h00, OK);
            e = (s > 1) ? 80 : 40;
            `CHK(n >= e - 2 && n <= e + 2, 1'h1)
        end
        $display("test interrupt points done");
    endtask : t_irq

    task automatic t_levels;
        for (int k = 0; k < 4; k++) begin
            wr(C0, {2'h1, k[1], k[0], 4'h1}, OK);
            wr(C1, 8'h01, OK);
            cyc(20);
            wr(C1, 8'h00, OK);
            cyc(4);
            `CHK(pwm_out, ~(k[1] ^ k[0]))
        end
        $display("test levels done");
    endtask : t_levels

    task automatic t_hold;
        period_value <= 16'h0028;
        wr(C0, 8'h01, OK);
        wr(C1, 8'h01, OK);
        wait_low();
        wr(C1, 8'h00, OK);
        cyc(10);
        `CHK(pwm_out, 1'h0)
        rd(C1, d, OK);
        `CHK(d, 8'h00)
        wr(pwmb_pkg::IDX_CNT_HI, 8'h5a, OK);
        rd(C1, d, OK);
        `CHK(d, 8'h40)
        rd(CL, d, OK);
        `CHK(d, 8'h00)
        $display("test hold and flag done");
    endtask : t_hold

    task automatic t_ext;
        for (int t = 0; t < 4; t++) begin
            wr(C2, 8'h00, OK);
            lvl_b <= (t == 2);
            lvl_a <= 1'h0;
            cyc(8);
            wr(C2, {4'h1, t[0], ~t[0], t[1:0]}, OK);
            lvl_a <= 1'h1;
            cyc(8);
            chk_stat(1'h0);
            lvl_b <= (t != 2);
            cyc(8);
            chk_stat(t == 1 || t == 2);
            lvl_b <= (t == 2);
            cyc(8);
            chk_stat(1'h0);
        end
        wr(C2, 8'h00, OK);
        lvl_a <= 1'h0;
        lvl_b <= 1'h0;
        $display("test external start done");
    endtask : t_ext

    task automatic t_clear;
        for (int t = 0; t < 4; t++) begin
            lvl_a <= 1'h0;
            wr(C2, {6'h03, t[1:0]}, OK);
            wr(CL, 8'h00, OK);
            wr(C1, 8'h01, OK);
            cyc(2);
            wait_low();
            lvl_a <= 1'h1;
            cyc(8);
            `CHK(pwm_out, t[1])
            wr(C1, 8'h00, OK);
        end
        duty_value <= 16'h0030;
        for (int c = 0; c < 2; c++) begin
            lvl_a <= 1'h0;
            wr(C0, {c[0], 7'h01}, OK);
            wr(C2, 8'h0e, OK);
            wr(C1, 8'h01, OK);
            wr(CL, 8'h00, OK);
            cyc(40);
            lvl_a <= 1'h1;
            cyc(8);
            wr(C1, 8'h00, OK);
            rd(CL, d, OK);
            `CHK(d > 8'h0c, c[0])
        end
        duty_value <= 16'h0002;
        wr(C2, 8'h00, OK);
        lvl_a <= 1'h0;
        period_value <= 16'h0004;
        $display("test external clear done");
    endtask : t_clear

    task automatic t_coop;
        wr(C2, 8'h10, OK);
        cooperation_mode <= 1'h1;
        partner_start_mode <= 2'h2;
        partner_trigger_edge <= 2'h1;
        cyc(8);
        lvl_a <= 1'h1;
        cyc(8);
        chk_stat(1'h1);
        lvl_a <= 1'h0;
        cyc(8);
        chk_stat(1'h0);
        partner_start_mode <= 2'h0;
        period_value <= 16'h0028;
        wr(C0, 8'h41, OK);
        wr(C1, 8'h01, OK);
        wait_low();
        wr(C1, 8'h00, OK);
        cyc(4);
        `CHK(pwm_out, 1'h0)
        partner_count_run <= 1'h1;
        cyc(2);
        partner_count_run <= 1'h0;
        cyc(4);
        `CHK(pwm_out, 1'h1)
        period_value <= 16'h0004;
        cooperation_mode <= 1'h0;
        partner_trigger_edge <= 2'h0;
        wr(C2, 8'h00, OK);
        $display("test cooperation done");
    endtask : t_coop

    task automatic t_misc;
        wr(C2, 8'h40, OK);
        wr(CL, 8'h00, OK);
        wr(C1, 8'h01, OK);
        cyc(60);
        chk_stat(1'h0);
        wr(C2, 8'h00, OK);
        wr(C1, 8'h01, OK);
        cyc(60);
        chk_stat(1'h1);
        wr(C0, 8'h03, OK);
        cyc(4);
        chk_stat(1'h0);
        wr(C0, 8'h02, OK);
        wr(C1, 8'h01, OK);
        xclk_on <= 1'h1;
        n_irq = 0;
        cyc(300);
        `CHK(n_irq >= 9 && n_irq <= 11, 1'h1)
        xclk_on <= 1'h0;
        cyc(10);
        n_irq = 0;
        cyc(100);
        `CHK(n_irq, 0)
        wr(C1, 8'h00, OK);
        $display("test one-shot and clocks done");
    endtask : t_misc

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_regs();
        t_irq();
        t_levels();
        t_hold();
        t_ext();
        t_clear();
        t_coop();
        t_misc();
        end_sim();
    end
endmodule : testbench
